/* File: rtl/dmac_chan_ctrl.sv */
// Four-channel DMA control, operation register and transfer sequencing
//
// The placing of the registers and the APB slave port were left to the implementer.
module dmac_chan_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby,
  input wire logic nmi_event,
  input wire logic addr_error_event,
  input wire logic [3:0] module_req,
  input wire logic [1:0] transfer_request_in_n,
  output logic [1:0] transfer_ack_out,
  output logic [3:0] transfer_end_irq,
  output logic xfer_active,
  output logic [1:0] xfer_chan,
  output logic xfer_write_cycle,
  output logic xfer_word,
  output logic xfer_burst
);
  import dmac_pkg::*;

  default clocking dmac_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  dmac_main_s main_r;
  dmac_main_s main_nxt;
  logic acc;
  logic rd;
  logic wr;
  logic aligned;
  logic is_cc;
  logic is_cnt;
  logic is_dor;
  logic is_rm;
  logic unmapped;
  logic [1:0] idx;
  logic [3:0] en;
  logic [3:0] req;
  logic [3:0] elig;
  logic [1:0] consume;
  logic [1:0] ext_req;
  logic gv;
  logic [1:0] gch;
  logic start;
  logic abort;

  // Channel may run: enabled, master on, no blocking flag
  function automatic logic dmac_chan_ok(input dmac_main_s s, input logic [1:0] c);
    return s.ctl[c][CC_CE] & s.me & ~s.ctl[c][CC_TE] & ~s.aef & ~s.nonmaskable_abort_flag;
  endfunction : dmac_chan_ok

  assign acc = psel & penable;
  assign rd = acc & ~pwrite;
  assign wr = acc & pwrite;
  assign idx = paddr[3:2];
  assign aligned = paddr[1:0] == 2'b00;
  assign is_cc = aligned & (paddr[7:4] == CHANNEL_CONTROL_BASE_OFF[7:4]);
  assign is_cnt = aligned & (paddr[7:4] == COUNT_BASE_OFF[7:4]);
  assign is_dor = paddr == DMA_OPERATION_OFF;
  assign is_rm = paddr == REQMODE_OFF;
  assign unmapped = ~(is_cc | is_cnt | is_dor | is_rm);
  assign pready = 1'b1;
  assign pslverr = acc & unmapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (is_cc) begin
      prdata[7:0] = main_r.ctl[idx];
    end else if (is_cnt) begin
      prdata[15:0] = main_r.cnt[idx];
    end else if (is_dor) begin
      // Other bits stay zero
      prdata[DO_PR+:2] = main_r.prio;
      prdata[DO_AE] = main_r.aef;
      prdata[DO_NMI] = main_r.nonmaskable_abort_flag;
      prdata[DO_ME] = main_r.me;
    end else if (is_rm) begin
      prdata[3:0] = main_r.auto_m;
      prdata[RM_EXT+:2] = main_r.ext_m;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign en[g] = dmac_chan_ok(main_r, 2'(g));
    if (g < 2) begin : g_ext
      dmac_req_det u_det (
        .pclk(pclk),
        .presetn(presetn),
        .standby(standby),
        .req_pin_n(transfer_request_in_n[g]),
        .sense_edge(main_r.ctl[g][CC_RS]),
        .consume(consume[g]),
        .req_out(ext_req[g])
      );
      assign consume[g] = start & (gch == 2'(g));
      assign req[g] = main_r.auto_m[g] | (main_r.ext_m[g] ? ext_req[g] : module_req[g]);
    end else begin : g_int
      assign req[g] = main_r.auto_m[g] | module_req[g];
    end
    assign transfer_end_irq[g] = main_r.ctl[g][CC_TE] & main_r.ctl[g][CC_IE];
  end

  assign elig = en & req;

  dmac_arb u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .standby(standby),
    .prio_mode(main_r.prio),
    .req(elig),
    .served(start),
    .served_ch(gch),
    .grant_valid(gv),
    .grant_ch(gch)
  );

  assign start = (main_r.st == DMAC_IDLE) & gv & ~standby;
  assign abort = ~en[main_r.ch] | nmi_event | addr_error_event;

  always_comb begin
    main_nxt = main_r;
    if (wr && is_cc) begin
      main_nxt.ctl[idx][CC_CE] = pwdata[CC_CE];
      main_nxt.ctl[idx][CC_IE] = pwdata[CC_IE];
      main_nxt.ctl[idx][CC_US] = pwdata[CC_US];
      main_nxt.ctl[idx][CC_BM] = pwdata[CC_BM];
      if (idx < 2'd2) begin
        main_nxt.ctl[idx][CC_RS] = pwdata[CC_RS];
        main_nxt.ctl[idx][CC_AP] = pwdata[CC_AP];
        main_nxt.ctl[idx][CC_AK] = pwdata[CC_AK];
      end
      if (!pwdata[CC_TE] && main_r.te_arm[idx]) begin
        main_nxt.ctl[idx][CC_TE] = 1'b0;
        main_nxt.te_arm[idx] = 1'b0;
      end
    end
    if (rd && is_cc && main_r.ctl[idx][CC_TE]) begin
      main_nxt.te_arm[idx] = 1'b1;
    end
    if (wr && is_dor) begin
      main_nxt.prio = dmac_prio_e'(pwdata[DO_PR+:2]);
      main_nxt.me = pwdata[DO_ME];
      if (!pwdata[DO_AE] && main_r.ae_arm) begin
        main_nxt.aef = 1'b0;
        main_nxt.ae_arm = 1'b0;
      end
      if (!pwdata[DO_NMI] && main_r.nmi_arm) begin
        main_nxt.nonmaskable_abort_flag = 1'b0;
        main_nxt.nmi_arm = 1'b0;
      end
    end
    if (rd && is_dor) begin
      if (main_r.aef) begin
        main_nxt.ae_arm = 1'b1;
      end
      if (main_r.nonmaskable_abort_flag) begin
        main_nxt.nmi_arm = 1'b1;
      end
    end
    if (wr && is_cnt) begin
      main_nxt.cnt[idx] = pwdata[15:0];
    end
    if (wr && is_rm) begin
      main_nxt.auto_m = pwdata[3:0];
      main_nxt.ext_m = pwdata[RM_EXT+:2];
    end
    // Hardware sets win over software clears
    if (nmi_event) begin
      main_nxt.nonmaskable_abort_flag = 1'b1;
    end
    if (addr_error_event) begin
      main_nxt.aef = 1'b1;
    end
    unique case (main_r.st)
      DMAC_IDLE: begin
        if (start) begin
          main_nxt.st = DMAC_RD;
          main_nxt.ch = gch;
        end
      end
      DMAC_RD: begin
        if (abort) begin
          main_nxt.st = DMAC_IDLE;
        end else begin
          main_nxt.st = DMAC_WR;
        end
      end
      DMAC_WR: begin
        if (abort) begin
          main_nxt.st = DMAC_IDLE;
        end else begin
          main_nxt.cnt[main_r.ch] = main_r.cnt[main_r.ch] - COUNT_ONE;
          if (main_r.cnt[main_r.ch] == COUNT_ONE) begin
            main_nxt.ctl[main_r.ch][CC_TE] = 1'b1;
            main_nxt.st = DMAC_IDLE;
          end else if (main_r.ctl[main_r.ch][CC_BM]) begin
            main_nxt.st = DMAC_RD;
          end else begin
            main_nxt.st = DMAC_IDLE;
          end
        end
      end
      default: begin
        main_nxt.st = DMAC_IDLE;
      end
    endcase
    if (standby) begin
      main_nxt = MAIN_RST;
    end
    // Acknowledge in read or write cycle of an external-request unit
    for (int c = 0; c < 2; c++) begin
      main_nxt.ack[c] = main_nxt.ctl[c][CC_AP] ^
        (main_nxt.st != DMAC_IDLE && main_nxt.ch == 2'(c) && main_nxt.ext_m[c] &&
         ((main_nxt.st == DMAC_WR) == main_nxt.ctl[c][CC_AK]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_r <= MAIN_RST;
    end else begin
      main_r <= main_nxt;
    end
  end

  assign transfer_ack_out = main_r.ack;
  assign xfer_active = main_r.st != DMAC_IDLE;
  assign xfer_chan = main_r.ch;
  assign xfer_write_cycle = main_r.st == DMAC_WR;
  assign xfer_word = main_r.ctl[main_r.ch][CC_US];
  assign xfer_burst = main_r.ctl[main_r.ch][CC_BM];

  logic [15:0] cnt_ch;
  logic te_ch;
  logic start_ok;
  logic te_hold;
  assign cnt_ch = main_r.cnt[main_r.ch];
  assign te_ch = main_r.ctl[main_r.ch][CC_TE];
  assign start_ok = start & en[gch] & req[gch];
  assign te_hold = wr & is_cc & ~pwdata[CC_TE] & ~main_r.te_arm[idx] & main_r.ctl[idx][CC_TE];

  sequence s_unit_start;
    main_r.st == DMAC_IDLE ##1 main_r.st == DMAC_RD;
  endsequence
  sequence s_unit_end;
    main_r.st == DMAC_WR && !abort && !standby;
  endsequence

  count_dec_a: assert property (s_unit_end |=> cnt_ch == $past(cnt_ch) - COUNT_ONE)
    else $error("count not decremented by one");
  end_flag_a: assert property ((s_unit_end and cnt_ch == COUNT_ONE) |=> te_ch)
    else $error("end flag not set at zero count");
  abort_flag_a: assert property ((main_r.st != DMAC_IDLE && abort && !te_ch) |=> !te_ch)
    else $error("end flag set on aborted unit");
  start_gate_a: assert property (s_unit_start |-> $past(start_ok))
    else $error("unit started without enable and request");
  enable_stop_a: assert property ((main_r.st != DMAC_IDLE && !en[main_r.ch]) |=> main_r.st == DMAC_IDLE)
    else $error("disabled channel kept transferring");
  end_irq_a: assert property (($rose(te_ch) && main_r.ctl[main_r.ch][CC_IE]) |-> transfer_end_irq[main_r.ch])
    else $error("end interrupt missing");
  rsv_zero_a: assert property ((rd && is_dor) |-> (prdata[15:10] == 6'h00 && prdata[7:3] == 5'h00))
    else $error("reserved operation bits not zero");
  flag_keep_a: assert property (te_hold |=> main_r.ctl[$past(idx)][CC_TE])
    else $error("end flag cleared without prior read");
  standby_clr_a: assert property (standby |=> (main_r.me == 1'b0 && main_r.prio == DMAC_PR_FIX0 && main_r.ctl == '0))
    else $error("standby did not clear registers");
  ack_idle_a: assert property ((main_r.st == DMAC_IDLE) |->
    transfer_ack_out == {main_r.ctl[1][CC_AP], main_r.ctl[0][CC_AP]})
    else $error("acknowledge active while idle");
  upper_ctl_a: assert property ((main_r.ctl[2][7:5] == 3'h0) && (main_r.ctl[3][7:5] == 3'h0))
    else $error("pin controls set on channel 2 or 3");
  nmi_block_a: assert property ((nmi_event && !standby) |=> (main_r.nonmaskable_abort_flag && en == 4'h0))
    else $error("abort flag not blocking channels");
  ae_block_a: assert property ((addr_error_event && !standby) |=> (main_r.aef && en == 4'h0))
    else $error("address error flag not blocking channels");

  // Flags hold until cleared through the read-one path or by standby
  ae_keep_a: assert property (
    (main_r.aef && !main_r.ae_arm && !standby) |=> main_r.aef)
    else $error("address error flag cleared without prior read");
  nmi_keep_a: assert property (
    (main_r.nonmaskable_abort_flag && !main_r.nmi_arm && !standby) |=> main_r.nonmaskable_abort_flag)
    else $error("abort flag cleared without prior read");
  flag_gate_a: assert property (
    (main_r.aef || main_r.nonmaskable_abort_flag) |-> en == 4'h0)
    else $error("channel enabled while a blocking flag is set");
  me_gate_a: assert property (
    !main_r.me |-> en == 4'h0)
    else $error("channel enabled with master enable off");
  te_block_a: assert property (
    (main_r.st == DMAC_IDLE && gv) |-> !main_r.ctl[gch][CC_TE])
    else $error("grant to a channel with end flag set");
  auto_start_a: assert property (
    (main_r.st == DMAC_IDLE && (en & main_r.auto_m) != 4'h0 && !standby) |=> main_r.st == DMAC_RD)
    else $error("auto request channel did not start");

  // Unit sequencing: read, write, then idle or next read
  rd_wr_a: assert property (
    (main_r.st == DMAC_RD && !abort && !standby) |=> main_r.st == DMAC_WR)
    else $error("read cycle not followed by write cycle");
  burst_next_a: assert property (
    (s_unit_end and (cnt_ch != COUNT_ONE && xfer_burst)) |=> main_r.st == DMAC_RD)
    else $error("burst did not continue");
  steal_gap_a: assert property (
    (s_unit_end and !xfer_burst) |=> main_r.st == DMAC_IDLE)
    else $error("cycle steal unit not followed by idle");
  abort_keep_a: assert property (
    (main_r.st == DMAC_WR && abort && !standby && !(wr && is_cnt)) |=> cnt_ch == $past(cnt_ch))
    else $error("count changed by aborted unit");
  standby_flag_a: assert property (
    standby |=> (!main_r.aef && !main_r.nonmaskable_abort_flag && !xfer_active))
    else $error("standby left flags or transfer active");
endmodule : dmac_chan_ctrl

/* File: rtl/dmac_pkg.sv */
// Shared constants and types for the DMA channel control block
package dmac_pkg;
  localparam int NCH = 4;
  localparam logic [7:0] CHANNEL_CONTROL_BASE_OFF = 8'h00;
  localparam logic [7:0] DMA_OPERATION_OFF = 8'h10;
  localparam logic [7:0] REQMODE_OFF = 8'h14;
  localparam logic [7:0] COUNT_BASE_OFF = 8'h20;
  localparam int CC_CE = 0;
  localparam int CC_TE = 1;
  localparam int CC_IE = 2;
  localparam int CC_US = 3;
  localparam int CC_BM = 4;
  localparam int CC_RS = 5;
  localparam int CC_AP = 6;
  localparam int CC_AK = 7;
  localparam int DO_ME = 0;
  localparam int DO_NMI = 1;
  localparam int DO_AE = 2;
  localparam int DO_PR = 8;
  localparam int RM_EXT = 4;
  localparam logic [15:0] DMA_OPERATION_RST = 16'h0000;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // Priority orders, two bits per entry, entry 0 highest
  localparam logic [7:0] ORD_FIX0 = 8'h6C;
  localparam logic [7:0] ORD_FIX1 = 8'h2D;
  localparam logic [7:0] ORD_RR_RST = 8'h6C;
  localparam logic [7:0] ORD_PIN_RST = 8'h1B;
  localparam logic PIN_IDLE = 1'b1;
  typedef enum logic [1:0] {DMAC_PR_FIX0, DMAC_PR_FIX1, DMAC_PR_RR, DMAC_PR_PINRR} dmac_prio_e;
  typedef enum logic [1:0] {DMAC_IDLE, DMAC_RD, DMAC_WR} dmac_state_e;
  typedef struct packed {
    logic [NCH-1:0][7:0] ctl;
    logic [NCH-1:0][15:0] cnt;
    dmac_prio_e prio;
    logic me;
    logic nonmaskable_abort_flag;
    logic aef;
    logic [3:0] auto_m;
    logic [1:0] ext_m;
    logic [3:0] te_arm;
    logic nmi_arm;
    logic ae_arm;
    dmac_state_e st;
    logic [1:0] ch;
    logic [1:0] ack;
  } dmac_main_s;
  localparam dmac_main_s MAIN_RST = '{ctl: '0, cnt: '0, prio: DMAC_PR_FIX0, st: DMAC_IDLE, default: '0};
  typedef struct packed {
    logic [7:0] rr_ord;
    logic [7:0] pin_ord;
  } dmac_arb_s;
  localparam dmac_arb_s ARB_RST = '{rr_ord: ORD_RR_RST, pin_ord: ORD_PIN_RST};
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pend;
  } dmac_det_s;
  localparam dmac_det_s DET_RST = '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, pend: 1'b0};
endpackage : dmac_pkg

/* File: rtl/dmac_req_det.sv */
// Request pin synchroniser with low-level or falling-edge detection
module dmac_req_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby,
  input wire logic req_pin_n,
  input wire logic sense_edge,
  input wire logic consume,
  output logic req_out
);
  import dmac_pkg::*;
  dmac_det_s det_r;
  dmac_det_s det_nxt;

  always_comb begin
    det_nxt = det_r;
    det_nxt.s1 = req_pin_n;
    det_nxt.s2 = det_r.s1;
    det_nxt.s3 = det_r.s2;
    // Set wins over consume
    det_nxt.pend = (det_r.pend & ~consume) | (sense_edge & det_r.s3 & ~det_r.s2);
    if (standby) begin
      det_nxt.pend = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_r <= DET_RST;
    end else begin
      det_r <= det_nxt;
    end
  end

  assign req_out = sense_edge ? det_r.pend : ~det_r.s2;

  edge_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sense_edge && det_r.s3 && !det_r.s2 && !standby) |=> det_r.pend)
    else $error("falling edge not latched");
endmodule : dmac_req_det

/* File: rtl/dmac_arb.sv */
// Channel arbiter with fixed and rotating priority orders
module dmac_arb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby,
  input wire logic [1:0] prio_mode,
  input wire logic [3:0] req,
  input wire logic served,
  input wire logic [1:0] served_ch,
  output logic grant_valid,
  output logic [1:0] grant_ch
);
  import dmac_pkg::*;
  dmac_arb_s arb_r;
  dmac_arb_s arb_nxt;
  logic [7:0] order;

  // Served channel goes last, the rest keep their order
  function automatic logic [7:0] dmac_rotate(input logic [7:0] ord, input logic [1:0] ch);
    logic [7:0] o;
    int k;
    o = 8'h00;
    k = 0;
    for (int i = 0; i < 4; i++) begin
      if (ord[2*i+:2] != ch) begin
        o[2*k+:2] = ord[2*i+:2];
        k++;
      end
    end
    o[7:6] = ch;
    return o;
  endfunction : dmac_rotate

  always_comb begin
    order = ORD_FIX0;
    unique case (prio_mode)
      DMAC_PR_FIX0: order = ORD_FIX0;
      DMAC_PR_FIX1: order = ORD_FIX1;
      DMAC_PR_RR: order = arb_r.rr_ord;
      DMAC_PR_PINRR: order = arb_r.pin_ord;
    endcase
  end

  always_comb begin
    grant_valid = |req;
    grant_ch = order[1:0];
    for (int i = 3; i >= 0; i--) begin
      if (req[order[2*i+:2]]) begin
        grant_ch = order[2*i+:2];
      end
    end
  end

  always_comb begin
    arb_nxt = arb_r;
    if (served && prio_mode == DMAC_PR_RR) begin
      arb_nxt.rr_ord = dmac_rotate(arb_r.rr_ord, served_ch);
    end
    if (served && prio_mode == DMAC_PR_PINRR) begin
      arb_nxt.pin_ord = dmac_rotate(arb_r.pin_ord, served_ch);
    end
    if (standby) begin
      arb_nxt = ARB_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_r <= ARB_RST;
    end else begin
      arb_r <= arb_nxt;
    end
  end

  rr_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    (served && !standby && prio_mode == DMAC_PR_RR) |=> arb_r.rr_ord[7:6] == $past(served_ch))
    else $error("served channel not moved to lowest priority");
endmodule : dmac_arb

/* File: sim/dmac_req_model.sv */
// External requester on the channel 0 request pin, released on acknowledge
module dmac_req_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic ack,
  input wire logic ack_low,
  output logic req_n,
  output int n_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go_q = 1'b0;
  initial begin
    req_n = 1'b1;
    n_ack = 0;
  end
  // One request per rising go, held low until acknowledge, then released to the pull-up level
  always @(posedge pclk) begin
    go_q <= go;
    if (go && !go_q && req_n) begin
      req_n <= 1'b0;
    end
    if (!req_n && (ack ^ ack_low)) begin
      req_n <= 1'b1;
      n_ack <= n_ack + 1;
    end
  end
endmodule : dmac_req_model

/* File: sim/dmac_chan_ctrl_tb.sv */
// Self-checking bench for the DMA channel control block
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module dmac_chan_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dmac_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic standby = 1'b0;
  logic nmi_event = 1'b0;
  logic addr_error_event = 1'b0;
  logic [3:0] module_req = 4'h0;
  logic req0_n;
  logic [1:0] ack;
  logic [3:0] irq;
  logic xfer_active;
  logic [1:0] xfer_chan;
  logic xfer_word;
  logic xfer_burst;
  logic xfer_wc;
  int n_wc = 0;
  logic go = 1'b0;
  logic ack_low = 1'b0;
  logic act_q = 1'b0;
  logic [1:0] seen[$];
  int n_ack;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] r;
  logic e;

  always #2.5 pclk = ~pclk;

  dmac_chan_ctrl dmac_chan_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby(standby), .nmi_event(nmi_event), .addr_error_event(addr_error_event), .module_req(module_req),
    .transfer_request_in_n({1'b1, req0_n}), .transfer_ack_out(ack), .transfer_end_irq(irq),
    .xfer_active(xfer_active), .xfer_chan(xfer_chan), .xfer_write_cycle(xfer_wc), .xfer_word(xfer_word),
    .xfer_burst(xfer_burst));

  dmac_req_model dmac_req_model_inst (.pclk(pclk), .go(go), .ack(ack[0]), .ack_low(ack_low),
    .req_n(req0_n), .n_ack(n_ack));

  // Channel order of every transfer start from idle
  always @(posedge pclk) begin
    act_q <= xfer_active;
    if (xfer_active && !act_q) begin
      seen.push_back(xfer_chan);
    end
    if (xfer_wc) begin
      n_wc <= n_wc + 1;
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(r, exp)
  endtask : rd

  task automatic sb();
    standby <= 1'b1;
    @(posedge pclk);
    standby <= 1'b0;
    @(posedge pclk);
  endtask : sb

  task automatic pulse(input int k);
    if (k == 0) nmi_event <= 1'b1;
    else addr_error_event <= 1'b1;
    @(posedge pclk);
    nmi_event <= 1'b0;
    addr_error_event <= 1'b0;
  endtask : pulse

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    logic [1:0] ord [4][4];
    logic [7:0] em [2];
    int na;
    int nw;
    ord = '{'{0, 3, 2, 1}, '{1, 3, 2, 0}, '{0, 3, 2, 1}, '{3, 2, 1, 0}};
    em = '{8'h41, 8'hA1};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(DMA_OPERATION_OFF, 32'h0);
    rd(CHANNEL_CONTROL_BASE_OFF, 32'h0);
    wr(DMA_OPERATION_OFF, 32'hFFFF);
    rd(DMA_OPERATION_OFF, 32'h0301);
    wr(DMA_OPERATION_OFF, 32'h0);
    wr(CHANNEL_CONTROL_BASE_OFF + 8'h08, 32'hFF);
    rd(CHANNEL_CONTROL_BASE_OFF + 8'h08, 32'h1D);
    wr(CHANNEL_CONTROL_BASE_OFF + 8'h08, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    `CHK(e, 1'b1)
    $display("Test registers done");
    for (int m = 0; m < 4; m++) begin
      sb();
      rd(DMA_OPERATION_OFF, 32'h0);
      for (int i = 0; i < 4; i++) begin
        wr(COUNT_BASE_OFF + 8'(4 * i), 32'h1);
        wr(CHANNEL_CONTROL_BASE_OFF + 8'(4 * i), 32'h1);
      end
      wr(REQMODE_OFF, 32'h0F);
      seen.delete();
      nw = n_wc;
      wr(DMA_OPERATION_OFF, {22'h0, 2'(m), 8'h01});
      for (int t = 0; t < 100 && seen.size() < 4; t++) @(posedge pclk);
      `CHK(seen.size(), 4)
      for (int i = 0; i < 4 && i < seen.size(); i++) `CHK(seen[i], ord[m][i])
      rd(CHANNEL_CONTROL_BASE_OFF + 8'h04, 32'h03);
      `CHK(irq, 4'h0)
      `CHK(n_wc - nw, 4)
    end
    $display("Test priority done");
    sb();
    wr(COUNT_BASE_OFF + 8'h04, 32'h2);
    wr(REQMODE_OFF, 32'h02);
    wr(CHANNEL_CONTROL_BASE_OFF + 8'h04, 32'h0D);
    wr(DMA_OPERATION_OFF, 32'h1);
    for (int t = 0; t < 100 && irq[1] !== 1'b1; t++) @(posedge pclk);
    `CHK(irq, 4'b0010)
    `CHK(xfer_word, 1'b1)
    rd(COUNT_BASE_OFF + 8'h04, 32'h0);
    wr(COUNT_BASE_OFF + 8'h04, 32'h1);
    wr(CHANNEL_CONTROL_BASE_OFF + 8'h04, 32'h0D);
    repeat (20) @(posedge pclk);
    rd(CHANNEL_CONTROL_BASE_OFF + 8'h04, 32'h0F);
    rd(COUNT_BASE_OFF + 8'h04, 32'h1);
    wr(CHANNEL_CONTROL_BASE_OFF + 8'h04, 32'h0C);
    rd(CHANNEL_CONTROL_BASE_OFF + 8'h04, 32'h0C);
    `CHK(irq, 4'h0)
    $display("Test end flag done");
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      wr(COUNT_BASE_OFF + 8'h0C, 32'h1);
      wr(REQMODE_OFF, 32'h08);
      wr(CHANNEL_CONTROL_BASE_OFF + 8'h0C, 32'h1);
      wr(DMA_OPERATION_OFF, 32'h1);
      repeat (10) @(posedge pclk);
      rd(COUNT_BASE_OFF + 8'h0C, 32'h1);
      rd(DMA_OPERATION_OFF, k ? 32'h5 : 32'h3);
      wr(DMA_OPERATION_OFF, 32'h1);
      rd(DMA_OPERATION_OFF, 32'h1);
      repeat (10) @(posedge pclk);
      rd(COUNT_BASE_OFF + 8'h0C, 32'h0);
      rd(CHANNEL_CONTROL_BASE_OFF + 8'h0C, 32'h3);
      wr(CHANNEL_CONTROL_BASE_OFF + 8'h0C, 32'h1);
    end
    $display("Test abort flags done");
    sb();
    wr(COUNT_BASE_OFF + 8'h08, 32'h64);
    wr(REQMODE_OFF, 32'h04);
    wr(CHANNEL_CONTROL_BASE_OFF + 8'h08, 32'h11);
    wr(DMA_OPERATION_OFF, 32'h1);
    repeat (30) @(posedge pclk);
    `CHK(xfer_burst, 1'b1)
    wr(DMA_OPERATION_OFF, 32'h0);
    apb(1'b0, COUNT_BASE_OFF + 8'h08, 32'h0);
    na = int'(r[15:0]);
    `CHK(na > 0 && na < 100, 1'b1)
    repeat (10) @(posedge pclk);
    rd(COUNT_BASE_OFF + 8'h08, 32'(na));
    rd(CHANNEL_CONTROL_BASE_OFF + 8'h08, 32'h11);
    $display("Test master abort done");
    sb();
    wr(COUNT_BASE_OFF + 8'h08, 32'h1);
    wr(CHANNEL_CONTROL_BASE_OFF + 8'h08, 32'h1);
    wr(DMA_OPERATION_OFF, 32'h1);
    repeat (5) @(posedge pclk);
    rd(COUNT_BASE_OFF + 8'h08, 32'h1);
    module_req <= 4'h4;
    repeat (5) @(posedge pclk);
    module_req <= 4'h0;
    rd(COUNT_BASE_OFF + 8'h08, 32'h0);
    rd(CHANNEL_CONTROL_BASE_OFF + 8'h08, 32'h3);
    $display("Test module request done");
    foreach (em[k]) begin
      sb();
      wr(COUNT_BASE_OFF, 32'h1);
      wr(REQMODE_OFF, 32'h10);
      wr(CHANNEL_CONTROL_BASE_OFF, {24'h0, em[k]});
      wr(DMA_OPERATION_OFF, 32'h1);
      ack_low <= em[k][6];
      repeat (4) @(posedge pclk);
      `CHK(ack[0], em[k][6])
      na = n_ack;
      go <= 1'b1;
      for (int t = 0; t < 60 && n_ack == na; t++) @(posedge pclk);
      go <= 1'b0;
      repeat (6) @(posedge pclk);
      `CHK(n_ack, na + 1)
      rd(CHANNEL_CONTROL_BASE_OFF, {24'h0, em[k] | 8'h02});
      rd(COUNT_BASE_OFF, 32'h0);
    end
    $display("Test external request done");
    end_sim();
  end
endmodule : dmac_chan_ctrl_tb
